// File: flash_pkg.sv
package flash_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses on APB, index on serial bus)
    // ------------------------------------------------------------
    localparam logic [7:0] idx_id = 8'h00;
    localparam logic [7:0] idx_ctrl = 8'h01;
    localparam logic [7:0] idx_timeout = 8'h02;
    localparam logic [7:0] idx_status = 8'h03;
    localparam logic [7:0] addr_id = 8'h00;
    localparam logic [7:0] addr_ctrl = 8'h04;
    localparam logic [7:0] addr_timeout = 8'h08;
    localparam logic [7:0] addr_status = 8'h0c;

    // Value is arbitrary
    localparam logic [7:0] id_value = 8'h5a;
    localparam logic [7:0] ctrl_reset = 8'h00;
    localparam logic [7:0] timeout_reset = 8'h09;

    // Control field positions
    localparam int ctrl_out_on = 0;
    localparam int ctrl_strobe_use = 1;
    localparam int ctrl_strobe_level = 2;

    // Status field positions
    localparam int stat_flash = 0;
    localparam int stat_expired = 1;
    localparam int stat_shutdown = 2;

    // ------------------------------------------------------------
    // Serial bus
    // ------------------------------------------------------------
    localparam logic [6:0] slave_addr = 7'h30;
    localparam logic [3:0] bits_per_byte = 4'h8;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int clk_hz = 100_000_000;
    localparam int shutdown_ms = 100;
    localparam int shutdown_cycles = clk_hz / 1000 * shutdown_ms;
    localparam int flash_unit_us = 1000;
    localparam int flash_unit_cycles = clk_hz / 1_000_000 * flash_unit_us;

    typedef enum {st_idle, st_rx, st_ack, st_tx, st_mack} i2c_state_t;

    typedef struct packed {
        logic strobe_level;
        logic strobe_use;
        logic out_on;
    } ctrl_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
        logic write;
        logic valid;
    } reg_access_t;

endpackage

// File: flash_i2c_strobe.sv
`timescale 1ns/10ps
module flash_i2c_strobe #(
    parameter int shutdown_count = flash_pkg::shutdown_cycles,
    parameter int flash_unit = flash_pkg::flash_unit_cycles
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic strobe_in,
    output logic flash_on,
    output logic shutdown
);

    // ------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [1:0] strobe_sync;
    logic scl_d;
    logic sda_d;
    logic strobe_d;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            strobe_sync <= 2'h0;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            strobe_d <= 1'b0;
        end else begin
            // 100 MHz sampling leaves ample margin at 400 kHz
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            strobe_sync <= {strobe_sync[0], strobe_in};
            scl_d <= scl_sync[1];
            sda_d <= sda_sync[1];
            strobe_d <= strobe_sync[1];
        end
    end

    logic scl;
    logic sda;
    logic strobe;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic strobe_rise;

    assign scl = scl_sync[1];
    assign sda = sda_sync[1];
    assign strobe = strobe_sync[1];
    assign scl_rise = scl & ~scl_d;
    assign scl_fall = ~scl & scl_d;
    // SDA moving while SCL is high is a bus condition, never data
    assign bus_start = scl & scl_d & sda_d & ~sda;
    assign bus_stop = scl & scl_d & ~sda_d & sda;
    assign strobe_rise = strobe & ~strobe_d;

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    flash_pkg::ctrl_t ctrl;
    logic [7:0] timeout;
    logic expired;
    logic [7:0] status;
    logic [7:0] pointer;

    flash_pkg::reg_access_t i2c_acc;
    flash_pkg::reg_access_t apb_acc;
    logic flash_end_cmd;
    logic shut_event;

    assign status = {5'h00, shutdown, expired, flash_on};

    function automatic logic [7:0] read_reg(input logic [7:0] idx);
        case (idx)
            flash_pkg::idx_id: return flash_pkg::id_value;
            flash_pkg::idx_ctrl: return {5'h00, ctrl};
            flash_pkg::idx_timeout: return timeout;
            flash_pkg::idx_status: return status;
            default: return 8'h00;
        endcase
    endfunction

    logic [7:0] ptr_data;
    assign ptr_data = read_reg(pointer);
    logic apb_hit;
    logic [7:0] apb_idx;
    assign apb_idx = {2'h0, paddr[7:2]};
    assign apb_hit = (paddr[1:0] == 2'h0) && (apb_idx <= flash_pkg::idx_status);
    assign apb_acc.addr = apb_idx;
    assign apb_acc.data = pwdata[7:0];
    assign apb_acc.write = pwrite;
    assign apb_acc.valid = psel & penable & pready & apb_hit;

    logic ctrl_wr;
    logic [7:0] ctrl_wdata;
    logic to_wr;
    logic [7:0] to_wdata;

    always_comb begin
        ctrl_wr = 1'b0;
        ctrl_wdata = 8'h00;
        to_wr = 1'b0;
        to_wdata = 8'h00;
        // Bus master on the serial side wins a same-cycle clash
        if (apb_acc.valid && apb_acc.write) begin
            if (apb_acc.addr == flash_pkg::idx_ctrl) begin
                ctrl_wr = 1'b1;
                ctrl_wdata = apb_acc.data;
            end
            if (apb_acc.addr == flash_pkg::idx_timeout) begin
                to_wr = 1'b1;
                to_wdata = apb_acc.data;
            end
        end
        if (i2c_acc.valid && i2c_acc.write) begin
            if (i2c_acc.addr == flash_pkg::idx_ctrl) begin
                ctrl_wr = 1'b1;
                ctrl_wdata = i2c_acc.data;
            end
            if (i2c_acc.addr == flash_pkg::idx_timeout) begin
                to_wr = 1'b1;
                to_wdata = i2c_acc.data;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl <= flash_pkg::ctrl_t'(flash_pkg::ctrl_reset[2:0]);
            timeout <= flash_pkg::timeout_reset;
        end else begin
            if (shut_event) begin
                ctrl.out_on <= 1'b0;
            end else if (ctrl_wr) begin
                ctrl <= flash_pkg::ctrl_t'(ctrl_wdata[2:0]);
            end else if (flash_end_cmd) begin
                ctrl.out_on <= 1'b0;
            end
            if (to_wr) begin
                timeout <= to_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // APB slave: one wait state, error on unmapped address
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~apb_hit;
            if (psel && penable && !pready && !pwrite) begin
                prdata <= {24'h00_0000, read_reg(apb_idx)};
            end
        end
    end

    // ------------------------------------------------------------
    // Serial slave
    // ------------------------------------------------------------
    flash_pkg::i2c_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] rx_shift;
    logic [7:0] tx_shift;
    logic [1:0] phase;
    logic read_dir;
    logic master_nack;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= flash_pkg::st_idle;
            bit_cnt <= 4'h0;
            rx_shift <= 8'h00;
            tx_shift <= 8'h00;
            phase <= 2'h0;
            read_dir <= 1'b0;
            master_nack <= 1'b0;
            pointer <= 8'h00;
            sda_oe <= 1'b0;
            i2c_acc <= '0;
        end else begin
            i2c_acc.valid <= 1'b0;
            if (bus_stop) begin
                state <= flash_pkg::st_idle;
                sda_oe <= 1'b0;
            end else if (bus_start) begin
                // Also a repeated START: pointer is kept
                state <= flash_pkg::st_rx;
                bit_cnt <= 4'h0;
                phase <= 2'h0;
                sda_oe <= 1'b0;
            end else begin
                case (state)
                    flash_pkg::st_idle: begin
                        sda_oe <= 1'b0;
                    end
                    flash_pkg::st_rx: begin
                        if (scl_rise) begin
                            rx_shift <= {rx_shift[6:0], sda};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall &&
                                     bit_cnt == flash_pkg::bits_per_byte) begin
                            bit_cnt <= 4'h0;
                            case (phase)
                                2'h0: begin
                                    if (rx_shift[7:1] == flash_pkg::slave_addr) begin
                                        read_dir <= rx_shift[0];
                                        sda_oe <= 1'b1;
                                        state <= flash_pkg::st_ack;
                                    end else begin
                                        state <= flash_pkg::st_idle;
                                    end
                                    phase <= 2'h1;
                                end
                                2'h1: begin
                                    pointer <= rx_shift;
                                    sda_oe <= 1'b1;
                                    state <= flash_pkg::st_ack;
                                    phase <= 2'h2;
                                end
                                default: begin
                                    i2c_acc.addr <= pointer;
                                    i2c_acc.data <= rx_shift;
                                    i2c_acc.write <= 1'b1;
                                    i2c_acc.valid <= 1'b1;
                                    pointer <= pointer + 8'h01;
                                    sda_oe <= 1'b1;
                                    state <= flash_pkg::st_ack;
                                end
                            endcase
                        end
                    end
                    flash_pkg::st_ack: begin
                        // Ack held from SCL fall to SCL fall
                        if (scl_fall) begin
                            if (read_dir) begin
                                tx_shift <= ptr_data;
                                sda_oe <= ~ptr_data[7];
                                bit_cnt <= 4'h0;
                                state <= flash_pkg::st_tx;
                            end else begin
                                sda_oe <= 1'b0;
                                state <= flash_pkg::st_rx;
                            end
                        end
                    end
                    flash_pkg::st_tx: begin
                        if (scl_fall) begin
                            if (bit_cnt == flash_pkg::bits_per_byte - 4'h1) begin
                                sda_oe <= 1'b0;
                                pointer <= pointer + 8'h01;
                                state <= flash_pkg::st_mack;
                            end else begin
                                tx_shift <= {tx_shift[6:0], 1'b0};
                                sda_oe <= ~tx_shift[6];
                                bit_cnt <= bit_cnt + 4'h1;
                            end
                        end
                    end
                    flash_pkg::st_mack: begin
                        if (scl_rise) begin
                            master_nack <= sda;
                        end else if (scl_fall) begin
                            if (master_nack) begin
                                state <= flash_pkg::st_idle;
                            end else begin
                                tx_shift <= ptr_data;
                                sda_oe <= ~ptr_data[7];
                                bit_cnt <= 4'h0;
                                state <= flash_pkg::st_tx;
                            end
                        end
                    end
                    default: state <= flash_pkg::st_idle;
                endcase
            end
        end
    end

    // Open drain: only ever pulls low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Shutdown watchdog on SCL low
    // ------------------------------------------------------------
    logic [23:0] scl_low_cnt;

    assign shut_event = (scl_low_cnt == 24'(shutdown_count - 1)) &&
                        (flash_on || ctrl.out_on);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_low_cnt <= 24'h00_0000;
            shutdown <= 1'b0;
        end else begin
            if (scl) begin
                scl_low_cnt <= 24'h00_0000;
            end else if (scl_low_cnt != 24'(shutdown_count - 1)) begin
                scl_low_cnt <= scl_low_cnt + 24'h00_0001;
            end
            if (shut_event) begin
                shutdown <= 1'b1;
            end else if (ctrl_wr) begin
                shutdown <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Flash start and duration
    // ------------------------------------------------------------
    logic [23:0] unit_cnt;
    logic [7:0] elapsed;
    logic time_up;
    logic start_cmd;

    assign time_up = flash_on && (elapsed == timeout) &&
                     (unit_cnt == 24'(flash_unit - 1));
    // A write that sets out_on fires the flash in command mode
    assign start_cmd = ctrl_wr && ctrl_wdata[flash_pkg::ctrl_out_on] &&
                       !ctrl_wdata[flash_pkg::ctrl_strobe_use];
    assign flash_end_cmd = time_up ||
                           (flash_on && ctrl.strobe_use &&
                            ctrl.strobe_level && !strobe);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flash_on <= 1'b0;
            expired <= 1'b0;
            unit_cnt <= 24'h00_0000;
            elapsed <= 8'h00;
        end else begin
            if (flash_on) begin
                if (unit_cnt == 24'(flash_unit - 1)) begin
                    unit_cnt <= 24'h00_0000;
                    elapsed <= elapsed + 8'h01;
                end else begin
                    unit_cnt <= unit_cnt + 24'h00_0001;
                end
            end else begin
                unit_cnt <= 24'h00_0000;
                elapsed <= 8'h00;
            end
            if (shut_event) begin
                flash_on <= 1'b0;
            end else if (flash_on) begin
                if (time_up) begin
                    flash_on <= 1'b0;
                    expired <= 1'b1;
                end else if (ctrl.strobe_use && ctrl.strobe_level &&
                             !strobe) begin
                    flash_on <= 1'b0;
                end else if (ctrl_wr &&
                             !ctrl_wdata[flash_pkg::ctrl_out_on]) begin
                    flash_on <= 1'b0;
                end
            end else if (start_cmd) begin
                flash_on <= 1'b1;
                expired <= 1'b0;
            end else if (ctrl.out_on && ctrl.strobe_use) begin
                if (!ctrl.strobe_level && strobe_rise) begin
                    flash_on <= 1'b1;
                    expired <= 1'b0;
                end else if (ctrl.strobe_level && strobe_rise) begin
                    // Level mode restarts only on a fresh high level
                    flash_on <= 1'b1;
                    expired <= 1'b0;
                end
            end
        end
    end
endmodule

// File: flash_props.sv
`timescale 1ns/10ps
module flash_props #(
    parameter int shutdown_count = 200,
    parameter int flash_unit = 20
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic strobe_in,
    input wire logic flash_on,
    input wire logic shutdown
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);

    // ------------
    // Helper state
    // ------------
    // Mode follows APB writes only; serial writes to it go unseen here
    logic [2:0] mode;
    int low_cnt;
    int on_cnt;
    logic wr_ctrl;
    assign wr_ctrl = psel && penable && pready && pwrite
        && paddr == flash_pkg::addr_ctrl;

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            mode <= 3'h0;
        else if (wr_ctrl)
            mode <= pwdata[2:0];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            low_cnt <= 0;
        else
            low_cnt <= scl_in ? 0 : low_cnt + 1;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            on_cnt <= 0;
        else
            on_cnt <= flash_on ? on_cnt + 1 : 0;
    end

    // ----------
    // Properties
    // ----------
    a_cmd_start:
        assert property (wr_ctrl && pwdata[1:0] == 2'b01 && !shutdown
            |-> ##[1:2] flash_on) else $error("flash did not start");
    a_flash_bound:
        assert property (on_cnt <= 256 * flash_unit + 2)
            else $error("flash outlived its limit");
    a_edge_start:
        assert property (mode[1:0] == 2'b11 && $rose(strobe_in)
            |-> ##[1:6] flash_on) else $error("trigger did not start");
    a_edge_hold:
        assert property (mode == 3'b011 && flash_on && $fell(strobe_in)
            |-> ##4 flash_on) else $error("edge flash cut by pin");
    a_level_end:
        assert property (mode[2:1] == 2'b11 && $fell(strobe_in)
            |-> ##[1:6] !flash_on) else $error("level flash kept on");
    a_sda_quiet:
        assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
            else $error("sda moved while scl high");
    a_shut_late:
        assert property ($rose(shutdown) |-> low_cnt >= shutdown_count)
            else $error("shutdown too early");
    a_shut_due:
        assert property (flash_on |-> low_cnt <= shutdown_count + 8)
            else $error("shutdown missing");
    a_apb_answer:
        assert property (psel && penable && !pready |=> pready)
            else $error("apb answer late");
    a_ready_pulse:
        assert property (pready |=> !pready)
            else $error("pready longer than one cycle");
endmodule

bind flash_i2c_strobe flash_props #(
    .shutdown_count(shutdown_count),
    .flash_unit(flash_unit)
) flash_props_i (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .strobe_in(strobe_in), .flash_on(flash_on), .shutdown(shutdown)
);

// File: i2c_master_model.sv
`timescale 1ns/10ps
module i2c_master_model (
    output logic scl,
    output logic sda_pull,
    input wire logic sda
);
    // Quarter bit time: one bit lasts four of them
    realtime q = 31.25;

    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    // Also serves as repeated START: lines go high before the fall
    task start();
        sda_pull = 1'b0;
        #q scl = 1'b1;
        #q sda_pull = 1'b1;
        #q scl = 1'b0;
        #q;
    endtask

    task stop();
        sda_pull = 1'b1;
        #q scl = 1'b1;
        #q sda_pull = 1'b0;
        #q;
    endtask

    // Eight data bits and the acknowledge bit, one clock each
    task byte_io(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            sda_pull = !tx[i];
            #q scl = 1'b1;
            #q rx[i] = sda;
            #q scl = 1'b0;
            #q;
        end
    endtask

    task park(input int ns);
        scl = 1'b0;
        #ns;
        scl = 1'b1;
    endtask
endmodule

// File: tb_top.sv
`timescale 1ns/10ps
module tb_top;
    localparam int unit = 20;
    logic clk, rst, psel, penable, pwrite, strobe_in;
    logic pready, pslverr, sda_out, sda_oe, flash_on, shutdown;
    logic scl, m_pull, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [8:0] rx;
    logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
    logic [31:0] rv [5] = '{32'(flash_pkg::id_value), 32'h0,
        32'(flash_pkg::timeout_reset), 32'h0, 32'h0};
    int errors, checks_done, cycles, n;
    wire logic sda;
    // Pull-up: the wire is low while either side pulls it
    assign sda = !(m_pull || sda_oe);

    flash_i2c_strobe #(.shutdown_count(200), .flash_unit(unit))
        flash_i2c_strobe_i (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .strobe_in(strobe_in), .flash_on(flash_on), .shutdown(shutdown)
    );
    i2c_master_model i2c_master_model_i (
        .scl(scl), .sda_pull(m_pull), .sda(sda)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // -------------
    // Bench helpers
    // -------------
    task tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            $display("BAD %0t run hung", $time);
            tally_and_finish();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp, string s);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t %s got %h want %h", $time, s, got, exp);
        end
    endtask

    // pready and the answer are taken at the rising edge that samples them
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task flash_run(input logic [2:0] m, input int hold, exp, tol);
        apb(1'b1, 8'h04, {29'h0, m});
        n = 0;
        fork
            if (hold > 0) begin
                strobe_in <= 1'b1;
                repeat (hold) @(posedge clk);
                strobe_in <= 1'b0;
            end
            begin
                for (int i = 0; i < 20 && flash_on !== 1'b1; i++)
                    @(negedge clk);
                while (flash_on === 1'b1 && n < 9000) begin
                    n++;
                    @(negedge clk);
                end
            end
        join
        chk(32'(n >= exp - tol && n <= exp + tol), 32'h1, "flash length");
    endtask

    task sbyte(input logic [7:0] d, input logic ack);
        i2c_master_model_i.byte_io({d, 1'b1}, rx);
        chk(32'(rx[0]), 32'(!ack), "ack bit");
    endtask

    task rbyte(input logic [7:0] exp, input logic last);
        i2c_master_model_i.byte_io({8'hff, last}, rx);
        chk(32'(rx[8:1]), 32'(exp), "read byte");
    endtask

    // -----
    // Tests
    // -----
    initial begin
        {rst, psel, penable, pwrite, strobe_in} = 5'b10000;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, ra[i], 32'h0);
            chk(rd, rv[i], "reset value");
            chk(32'(er), 32'(i == 4), "slave error");
        end
        apb(1'b1, 8'h00, 32'hff);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, rv[0], "id is read-only");
        $display("test registers done");
        apb(1'b1, 8'h08, 32'h2);
        flash_run(3'b001, 0, 3 * unit, 1);
        apb(1'b0, 8'h0c, 32'h0);
        chk(rd, 32'h1 << flash_pkg::stat_expired, "expired");
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h0, "arm cleared");
        flash_run(3'b011, 10, 3 * unit, 1);
        flash_run(3'b111, 30, 30, 3);
        flash_run(3'b111, 100, 3 * unit, 1);
        $display("test flash done");
        i2c_master_model_i.start();
        sbyte(8'h60, 1'b1);
        sbyte(8'h01, 1'b1);
        sbyte(8'h00, 1'b1);
        sbyte(8'h04, 1'b1);
        i2c_master_model_i.stop();
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h4, "serial write");
        i2c_master_model_i.start();
        sbyte(8'h60, 1'b1);
        sbyte(8'h00, 1'b1);
        i2c_master_model_i.start();
        sbyte(8'h61, 1'b1);
        rbyte(flash_pkg::id_value, 1'b0);
        rbyte(8'h00, 1'b0);
        rbyte(8'h04, 1'b1);
        repeat (4) @(negedge clk);
        chk(32'(sda_oe), 32'h0, "sda released");
        chk(32'(sda_out), 32'h0, "sda pull level");
        i2c_master_model_i.stop();
        i2c_master_model_i.start();
        sbyte(8'h60, 1'b1);
        sbyte(8'h02, 1'b1);
        i2c_master_model_i.stop();
        i2c_master_model_i.start();
        sbyte(8'h61, 1'b1);
        rbyte(8'h04, 1'b1);
        i2c_master_model_i.stop();
        i2c_master_model_i.start();
        sbyte(8'h62, 1'b0);
        i2c_master_model_i.stop();
        $display("test serial done");
        apb(1'b1, 8'h08, 32'hff);
        apb(1'b1, 8'h04, 32'h1);
        i2c_master_model_i.park(3000);
        chk(32'({flash_on, shutdown}), 32'h1, "shutdown");
        apb(1'b1, 8'h04, 32'h0);
        repeat (2) @(negedge clk);
        chk(32'(shutdown), 32'h0, "shutdown cleared");
        $display("test shutdown done");
        tally_and_finish();
    end
endmodule
